// [verilog/ctw_supervision.sv]
// Broken current-transformer wire supervision and asymmetrical VT fuse-failure monitor.
// Assumes measured magnitudes arrive already in the clk_in domain with a sample strobe.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "ctw_params.svh"

module ctw_supervision #(
    parameter int NLOC        = 3,                 // Measuring locations
    parameter int TICK_CYC    = `CTW_TICK_CYC,     // Clock cycles per timer tick
    parameter int DELAY_TICKS = `CTW_FFM_TICKS     // Ticks in the ten second window
) (
    input  wire logic                 clk_in,        // 100 MHz clock
    input  wire logic                 srst_in,       // Synchronous reset
    input  wire logic [7:0]           addr_in,       // Register byte address
    input  wire logic [31:0]          wr_data_in,    // Register write data
    input  wire logic                 wr_in,         // Write strobe
    input  wire logic                 rd_in,         // Read strobe
    output logic      [31:0]          rd_data_out,   // Read data, cycle after strobe
    input  wire logic                 sample_in,     // New measurement set strobe
    input  wire logic [NLOC*48-1:0]   cur_mag_in,    // Phase current magnitudes
    input  wire logic [NLOC*3-1:0]    zero_cross_in, // Zero crossing pulses per phase
    input  wire logic [15:0]          freq_in,       // System frequency, centihertz
    input  wire logic [15:0]          neg_seq_v_in,  // Negative sequence voltage
    input  wire logic [NLOC*16-1:0]   zero_seq_i_in, // Zero sequence current per location
    input  wire logic [NLOC*16-1:0]   neg_seq_i_in,  // Negative sequence current per location
    output logic      [NLOC-1:0]      diff_ref_block_out,   // Differential and REF block
    output logic      [NLOC-1:0]      resid_unbal_block_out, // Residual and unbalance block
    output logic      [NLOC*3-1:0]    broken_wire_out,      // Broken wire annunciation
    output logic                      vt_failure_block_out, // Undervoltage function block
    output logic                      irq_out               // Level interrupt
);
    localparam int NPH = NLOC * 3;
    localparam int CW  = $clog2(`CTW_ZC_SMP + 1);
    localparam int DW  = $clog2(TICK_CYC + 1);
    localparam int TW  = $clog2(DELAY_TICKS + 1);
    localparam logic [CW-1:0] STEADY_MAX = CW'(`CTW_STEADY_SMP);
    localparam logic [CW-1:0] ZC_MAX     = CW'(`CTW_ZC_SMP);
    localparam logic [DW-1:0] TICK_LAST  = DW'(TICK_CYC - 1);
    localparam logic [TW-1:0] DELAY_LAST = TW'(DELAY_TICKS - 1);

    // Refuse configurations the fixed register map or counters cannot serve
    if (NLOC < 1 || NLOC > 3) begin : g_bad_nloc
        $error("NLOC must be 1 to 3");
    end
    if (TICK_CYC < 1 || DELAY_TICKS < 1) begin : g_bad_time
        $error("Timer counts must be at least one");
    end

    // All state of the block
    typedef struct packed {
        logic [7:0]             ctrl;       // Enables and location selection
        logic [15:0]            i_rated;    // Rated current
        logic [15:0]            f_rated;    // Rated frequency
        logic [15:0]            v2_min;     // neg_seq_voltage_min_threshold
        logic [15:0]            i_sym;      // Sequence current symmetry limit
        logic [NLOC-1:0][15:0]  open_i;     // Open pole current per location
        logic [NLOC-1:0]        assign_m;   // Residual/unbalance assigned here
        logic [2:0]             irq_stat;   // Sticky events
        logic [2:0]             irq_mask;   // Interrupt enables
        logic [NPH-1:0]         armed;      // Steady current seen
        logic [NPH-1:0]         bw;         // Broken wire declared
        logic [NPH-1:0][CW-1:0] steady_cnt; // Samples with steady current
        logic [NPH-1:0][CW-1:0] zc_cnt;     // Samples since last crossing
        ctw_pkg::ctw_ffm_state_t ffm;       // Fuse failure sequence
        logic [TW-1:0]          ffm_tmr;    // Ten second window in ticks
        logic [DW-1:0]          div;        // Tick divider
        logic                   tick;       // One cycle tick enable
        logic [NLOC-1:0]        diff_blk;   // Registered outputs from here on
        logic [NLOC-1:0]        ru_blk;
        logic [NPH-1:0]         bw_ann;
        logic                   vt_blk;
        logic                   irq;
        logic [31:0]            rd_data;
    } ctw_state_t;

    ctw_state_t s;       // Present state
    ctw_state_t n;       // Next state

    // Measurement views
    logic [NPH-1:0][15:0]  cur;
    logic [NLOC-1:0][15:0] i0;
    logic [NLOC-1:0][15:0] i2;
    assign cur = cur_mag_in;
    assign i0  = zero_seq_i_in;
    assign i2  = neg_seq_i_in;

    // Current below a tenth of rated, used for detection and for release
    function automatic logic below_tenth(input logic [15:0] c, input logic [15:0] r);
        below_tenth = (20'(c) * 20'd10) < (20'(r) * 20'(`CTW_MIN_TENTHS));
    endfunction

    // Derived conditions
    logic [NPH-1:0] low;         // Phase below the minimum
    logic [NPH-1:0] oth_ok;      // Other phases of the location not overloaded
    logic [NPH-1:0] det;         // New broken wire this cycle
    logic           freq_ok;     // Frequency inside operating band
    logic           ffm_en;      // Monitor active for this object
    logic           crit_v;      // Voltage asymmetry
    logic           sym_i;       // Currents symmetrical on selected locations
    logic           cur_flow;    // Current above open pole limit on a selected location
    logic           crit;        // Full fuse-failure criterion
    logic [2:0]     vsel;        // Locations feeding the current criterion

    // Frequency band check; the wide products avoid any overflow at 16-bit inputs
    always_comb begin
        freq_ok = (32'(freq_in) * 32'd100 >= 32'(s.f_rated) * 32'(100 - `CTW_FREQ_TOL_PCT))
               && (32'(freq_in) * 32'd100 <= 32'(s.f_rated) * 32'(100 + `CTW_FREQ_TOL_PCT));
    end

    // Per-phase detection terms
    always_comb begin
        for (int p = 0; p < NPH; p++) begin
            low[p]    = below_tenth(cur[p], s.i_rated);
            oth_ok[p] = 1'b1;
            for (int q = (p / 3) * 3; q < (p / 3) * 3 + 3; q++) begin
                if (q != p && 17'(cur[q]) > 17'(s.i_rated) * 17'(`CTW_OTHER_MULT)) begin
                    oth_ok[p] = 1'b0;
                end
            end
            det[p] = s.ctrl[`CTW_CTRL_CT_EN] && freq_ok && s.armed[p] && oth_ok[p]
                  && !s.bw[p] && (low[p] || s.zc_cnt[p] == ZC_MAX);
        end
    end

    // Fuse-failure criteria over the locations selected in ctrl
    always_comb begin
        vsel     = s.ctrl[`CTW_CTRL_VSEL_HI:`CTW_CTRL_VSEL_LO];
        ffm_en   = s.ctrl[`CTW_CTRL_FFM_EN] && s.ctrl[`CTW_CTRL_3PH];
        crit_v   = neg_seq_v_in > s.v2_min;
        sym_i    = 1'b1;
        cur_flow = 1'b0;
        for (int l = 0; l < NLOC; l++) begin
            if (vsel[l]) begin
                if (i0[l] >= s.i_sym || i2[l] >= s.i_sym) begin
                    sym_i = 1'b0;
                end
                for (int k = 0; k < 3; k++) begin
                    if (cur[l * 3 + k] > s.open_i[l]) begin
                        cur_flow = 1'b1;
                    end
                end
            end
        end
        crit = ffm_en && crit_v && sym_i && cur_flow;
    end

    // Next state: registers, broken-wire tracking, fuse-failure sequence, outputs
    always_comb begin
        n = s;
        // Timer tick divider
        n.tick = 1'b0;
        if (s.div == TICK_LAST) begin
            n.div  = '0;
            n.tick = 1'b1;
        end else begin
            n.div = s.div + DW'(1);
        end

        // Register writes
        if (wr_in) begin
            case (addr_in)
                `CTW_ADDR_CTRL:    n.ctrl     = wr_data_in[7:0];
                `CTW_ADDR_IRATED:  n.i_rated  = wr_data_in[15:0];
                `CTW_ADDR_FRATED:  n.f_rated  = wr_data_in[15:0];
                `CTW_ADDR_V2MIN:   n.v2_min   = wr_data_in[15:0];
                `CTW_ADDR_ISYM:    n.i_sym    = wr_data_in[15:0];
                `CTW_ADDR_OPEN1:   n.open_i[0] = wr_data_in[15:0];
                `CTW_ADDR_OPEN2:   if (NLOC > 1) n.open_i[NLOC > 1 ? 1 : 0] = wr_data_in[15:0];
                `CTW_ADDR_OPEN3:   if (NLOC > 2) n.open_i[NLOC > 2 ? 2 : 0] = wr_data_in[15:0];
                `CTW_ADDR_ASSIGN:  n.assign_m = wr_data_in[NLOC-1:0];
                `CTW_ADDR_IRQMASK: n.irq_mask = wr_data_in[2:0];
                default: ;        // Read-only and unmapped writes are dropped
            endcase
        end

        // Broken-wire tracking per phase
        for (int p = 0; p < NPH; p++) begin
            if (zero_cross_in[p]) begin
                n.zc_cnt[p] = '0;
            end else if (sample_in && s.zc_cnt[p] != ZC_MAX) begin
                n.zc_cnt[p] = s.zc_cnt[p] + CW'(1);
            end
            if (det[p]) begin
                n.bw[p]         = 1'b1;
                n.armed[p]      = 1'b0;
                n.steady_cnt[p] = '0;
            end else if (s.bw[p]) begin
                if (!low[p]) begin
                    n.bw[p]     = 1'b0;
                    n.zc_cnt[p] = '0;
                end
            end else if (sample_in) begin
                // Arming needs an unbroken run of adequate current
                if (low[p]) begin
                    n.steady_cnt[p] = '0;
                    n.armed[p]      = 1'b0;
                end else if (s.steady_cnt[p] != STEADY_MAX) begin
                    n.steady_cnt[p] = s.steady_cnt[p] + CW'(1);
                end else begin
                    n.armed[p] = 1'b1;
                end
            end
        end

        // Fuse-failure sequence; timer counts ticks of the ten second window
        case (s.ffm)
            ctw_pkg::CTW_FFM_IDLE: begin
                if (crit) begin
                    n.ffm     = ctw_pkg::CTW_FFM_WAIT;
                    n.ffm_tmr = '0;
                end
            end
            ctw_pkg::CTW_FFM_WAIT: begin
                if (!ffm_en || !crit_v) begin
                    n.ffm = ctw_pkg::CTW_FFM_IDLE;
                end else if (!sym_i) begin
                    n.ffm = ctw_pkg::CTW_FFM_SHORT;
                end else if (s.tick) begin
                    if (s.ffm_tmr == DELAY_LAST) begin
                        n.ffm = ctw_pkg::CTW_FFM_LATCH;
                    end else begin
                        n.ffm_tmr = s.ffm_tmr + TW'(1);
                    end
                end
            end
            ctw_pkg::CTW_FFM_SHORT: begin
                // Unblocked while the fault lasts, then judged afresh
                if (!ffm_en || sym_i) begin
                    n.ffm = ctw_pkg::CTW_FFM_IDLE;
                end
            end
            ctw_pkg::CTW_FFM_LATCH: begin
                // Current asymmetry no longer releases here
                if (!ffm_en) begin
                    n.ffm = ctw_pkg::CTW_FFM_IDLE;
                end else if (!crit_v) begin
                    n.ffm     = ctw_pkg::CTW_FFM_HOLD;
                    n.ffm_tmr = '0;
                end
            end
            ctw_pkg::CTW_FFM_HOLD: begin
                if (!ffm_en) begin
                    n.ffm = ctw_pkg::CTW_FFM_IDLE;
                end else if (crit_v) begin
                    n.ffm = ctw_pkg::CTW_FFM_LATCH;
                end else if (s.tick) begin
                    if (s.ffm_tmr == DELAY_LAST) begin
                        n.ffm = ctw_pkg::CTW_FFM_IDLE;
                    end else begin
                        n.ffm_tmr = s.ffm_tmr + TW'(1);
                    end
                end
            end
            default: n.ffm = ctw_pkg::CTW_FFM_IDLE;
        endcase

        // Sticky events; a read clears, but a new event in the same cycle wins
        if (rd_in && addr_in == `CTW_ADDR_IRQSTAT) begin
            n.irq_stat = '0;
        end
        if (|det) begin
            n.irq_stat[`CTW_IRQ_BW] = 1'b1;
        end
        if (s.ffm == ctw_pkg::CTW_FFM_IDLE && crit) begin
            n.irq_stat[`CTW_IRQ_VTBLK] = 1'b1;
        end
        if (s.ffm != ctw_pkg::CTW_FFM_LATCH && n.ffm == ctw_pkg::CTW_FFM_LATCH) begin
            n.irq_stat[`CTW_IRQ_LATCH] = 1'b1;
        end

        // Read data stands only in the cycle after the strobe
        n.rd_data = '0;
        if (rd_in) begin
            case (addr_in)
                `CTW_ADDR_CTRL:    n.rd_data = {24'h000000, s.ctrl};
                `CTW_ADDR_IRATED:  n.rd_data = {16'h0000, s.i_rated};
                `CTW_ADDR_FRATED:  n.rd_data = {16'h0000, s.f_rated};
                `CTW_ADDR_V2MIN:   n.rd_data = {16'h0000, s.v2_min};
                `CTW_ADDR_ISYM:    n.rd_data = {16'h0000, s.i_sym};
                `CTW_ADDR_OPEN1:   n.rd_data = {16'h0000, s.open_i[0]};
                `CTW_ADDR_OPEN2:   n.rd_data = (NLOC > 1) ? {16'h0000, s.open_i[NLOC > 1 ? 1 : 0]}
                                                          : 32'h00000000;
                `CTW_ADDR_OPEN3:   n.rd_data = (NLOC > 2) ? {16'h0000, s.open_i[NLOC > 2 ? 2 : 0]}
                                                          : 32'h00000000;
                `CTW_ADDR_ASSIGN:  n.rd_data = 32'(s.assign_m);
                `CTW_ADDR_BWSTAT:  n.rd_data = 32'(s.bw);
                `CTW_ADDR_FFMSTAT: n.rd_data = {28'h0000000, s.vt_blk, s.ffm};
                `CTW_ADDR_IRQSTAT: n.rd_data = {29'h0, s.irq_stat};
                `CTW_ADDR_IRQMASK: n.rd_data = {29'h0, s.irq_mask};
                default:           n.rd_data = 32'h00000000;   // Unmapped reads as zero
            endcase
        end

        // Reset returns every latch, timer and block to inactive
        if (srst_in) begin
            n = '0;
            n.ctrl     = `CTW_CTRL_RST;
            n.i_rated  = `CTW_IRATED_RST;
            n.f_rated  = `CTW_FRATED_RST;
            n.v2_min   = `CTW_V2MIN_RST;
            n.i_sym    = `CTW_ISYM_RST;
            n.assign_m = NLOC'(`CTW_ASSIGN_RST);
            n.irq_mask = `CTW_MASK_RST;
            for (int l = 0; l < NLOC; l++) begin
                n.open_i[l] = `CTW_OPEN_RST;
            end
            n.ffm = ctw_pkg::CTW_FFM_IDLE;
        end

        // Outputs follow the next state so the blocks act in the detecting cycle's edge
        for (int l = 0; l < NLOC; l++) begin
            n.diff_blk[l] = |n.bw[l * 3 +: 3];
            n.ru_blk[l]   = n.diff_blk[l] && n.assign_m[l];
        end
        n.bw_ann = n.bw;
        n.vt_blk = n.ffm == ctw_pkg::CTW_FFM_WAIT || n.ffm == ctw_pkg::CTW_FFM_LATCH
                || n.ffm == ctw_pkg::CTW_FFM_HOLD;
        n.irq    = |(n.irq_stat & n.irq_mask);
    end

    // Single state register
    always_ff @(posedge clk_in) begin
        s <= n;
    end

    assign rd_data_out           = s.rd_data;
    assign diff_ref_block_out    = s.diff_blk;
    assign resid_unbal_block_out = s.ru_blk;
    assign broken_wire_out       = s.bw_ann;
    assign vt_failure_block_out  = s.vt_blk;
    assign irq_out               = s.irq;

    // Checks
    bw_detect_a: assert property (@(posedge clk_in) disable iff (srst_in)
        det[0] |=> s.bw[0] && broken_wire_out[0])
        else $error("Broken wire not declared after detection");
    other_phase_a: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(s.bw[0]) |-> $past(oth_ok[0]))
        else $error("Broken wire declared with overloaded other phase");
    diff_block_a: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(s.bw[0]) |-> diff_ref_block_out[0])
        else $error("Differential block missing with broken wire");
    resid_block_a: assert property (@(posedge clk_in) disable iff (srst_in)
        resid_unbal_block_out[0] |-> diff_ref_block_out[0] && s.assign_m[0])
        else $error("Residual block without assigned broken wire");
    bw_release_a: assert property (@(posedge clk_in) disable iff (srst_in)
        (s.bw[0] && !low[0] && !det[0]) |=> !broken_wire_out[0])
        else $error("Broken wire not released on returning current");
    arm_first_a: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(s.bw[0]) |-> $past(s.armed[0], 1))
        else $error("Broken wire declared while unarmed");
    freq_band_a: assert property (@(posedge clk_in) disable iff (srst_in)
        (!freq_ok && s.bw == '0) |=> s.bw == '0)
        else $error("Broken wire evaluated outside frequency band");
    vt_block_a: assert property (@(posedge clk_in) disable iff (srst_in)
        (s.ffm == ctw_pkg::CTW_FFM_IDLE && crit) |=> vt_failure_block_out)
        else $error("Fuse failure not blocked immediately");
    short_release_a: assert property (@(posedge clk_in) disable iff (srst_in)
        (s.ffm == ctw_pkg::CTW_FFM_WAIT && ffm_en && crit_v && !sym_i) |=>
        !vt_failure_block_out ##1 (s.ffm == ctw_pkg::CTW_FFM_SHORT || sym_i || !ffm_en))
        else $error("Short circuit did not release blocking");
    latch_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
        (s.ffm == ctw_pkg::CTW_FFM_LATCH && ffm_en && crit_v) |=>
        s.ffm == ctw_pkg::CTW_FFM_LATCH && vt_failure_block_out)
        else $error("Latched blocking released by currents");
    three_phase_a: assert property (@(posedge clk_in) disable iff (srst_in)
        !ffm_en |=> !vt_failure_block_out)
        else $error("Fuse monitor active without three-phase object");
    reset_clear_a: assert property (@(posedge clk_in)
        srst_in |=> s.bw == '0 && !vt_failure_block_out && s.ffm_tmr == '0)
        else $error("Reset left blocking active");
endmodule

// [verilog/ctw_params.svh]
// Constants for the CT broken-wire and VT fuse-failure supervision block.
// Assumes a 100 MHz system clock and a plain register port driven from that clock.
`ifndef CTW_PARAMS_SVH
`define CTW_PARAMS_SVH

// Register byte offsets
`define CTW_ADDR_CTRL     8'h00
`define CTW_ADDR_IRATED   8'h04
`define CTW_ADDR_FRATED   8'h08
`define CTW_ADDR_V2MIN    8'h0C
`define CTW_ADDR_ISYM     8'h10
`define CTW_ADDR_OPEN1    8'h14
`define CTW_ADDR_OPEN2    8'h18
`define CTW_ADDR_OPEN3    8'h1C
`define CTW_ADDR_ASSIGN   8'h20
`define CTW_ADDR_BWSTAT   8'h24
`define CTW_ADDR_FFMSTAT  8'h28
`define CTW_ADDR_IRQSTAT  8'h2C
`define CTW_ADDR_IRQMASK  8'h30

// Control register fields
`define CTW_CTRL_CT_EN    0
`define CTW_CTRL_FFM_EN   1
`define CTW_CTRL_3PH      2
`define CTW_CTRL_VSEL_LO  4
`define CTW_CTRL_VSEL_HI  6

// Interrupt status bits
`define CTW_IRQ_BW        0
`define CTW_IRQ_VTBLK     1
`define CTW_IRQ_LATCH     2

// Reset values
`define CTW_CTRL_RST      8'h17
`define CTW_IRATED_RST    16'h0400
`define CTW_FRATED_RST    16'h1388
`define CTW_V2MIN_RST     16'h0100
`define CTW_ISYM_RST      16'h0080
`define CTW_OPEN_RST      16'h0020
`define CTW_ASSIGN_RST    3'h7
`define CTW_MASK_RST      3'h0

// Detection figures
`define CTW_MIN_TENTHS    1
`define CTW_OTHER_MULT    2
`define CTW_FREQ_TOL_PCT  10
`define CTW_STEADY_SMP    16
`define CTW_ZC_SMP        64

// Timing
`define CTW_CLK_HZ        100000000
`define CTW_TICK_US       1000
`define CTW_TICK_CYC      ((`CTW_CLK_HZ / 1000000) * `CTW_TICK_US)
`define CTW_FFM_DELAY_S   10
`define CTW_FFM_TICKS     ((`CTW_FFM_DELAY_S * 1000000) / `CTW_TICK_US)

`endif

// [verilog/ctw_pkg.sv]
// Types shared by the CT broken-wire and VT fuse-failure supervision block.
// Assumes nothing beyond a SystemVerilog elaborator.
package ctw_pkg;
    // Fuse failure monitor sequence
    typedef enum logic [2:0] {
        CTW_FFM_IDLE,
        CTW_FFM_WAIT,
        CTW_FFM_SHORT,
        CTW_FFM_LATCH,
        CTW_FFM_HOLD
    } ctw_ffm_state_t;
endpackage

// [verif/ctw_frontend.sv]
// Model of the measurement front end: paces sample strobes and crossings.
// Assumes the bench sets the magnitudes itself.
`timescale 1ns/1ns
module ctw_frontend (
    input  wire logic       clk_in,     // System clock
    input  wire logic       srst_in,    // Synchronous reset
    output logic            sample_out, // Sample strobe every fourth cycle
    output logic [8:0]      zc_out      // Crossing pulse every eighth sample
);
    logic [4:0] cnt; // Pacing counter
    // Crossings come well inside the no-crossing timeout
    always_ff @(posedge clk_in) begin
        cnt        <= srst_in ? 5'h00 : cnt + 5'h01;
        sample_out <= (cnt[1:0] == 2'h3);
        zc_out     <= {9{cnt == 5'h1F}};
    end
endmodule

// [verif/test_ctw_supervision.sv]
// Bench for the supervision block: bus tasks and one task per scenario.
// Assumes short timer parameters: a 10 s window is 20 cycles here.
`timescale 1ns/1ns
`include "ctw_params.svh"
module test_ctw_supervision;
    logic         clk_in = 1'b0, srst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic [7:0]   addr_in = 8'h00;                    // Register address
    logic [31:0]  wr_data_in = 32'h0, rd_data_out, d; // Bus data
    logic [143:0] cur = {9{16'h0400}};                // Phases at rated
    logic [47:0]  i0 = 48'h0, i2 = 48'h0;             // Zero and negative sequence currents
    logic [8:0]   zc_off = 9'h000;                    // Phases whose crossings are withheld
    logic [15:0]  freq = 16'h1388, v2 = 16'h0000;     // Frequency, neg seq volts
    logic         sample_in, irq_out, vt;
    logic [8:0]   zc, bw;
    logic [2:0]   dblk, rblk;
    int           failures = 0, checks = 0;
    always #5 clk_in = ~clk_in;
    ctw_frontend i_ctw_frontend (.clk_in(clk_in), .srst_in(srst_in), .sample_out(sample_in),
        .zc_out(zc));
    ctw_supervision #(.TICK_CYC(4), .DELAY_TICKS(5)) i_ctw_supervision (.clk_in(clk_in),
        .srst_in(srst_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
        .rd_in(rd_in), .rd_data_out(rd_data_out), .sample_in(sample_in), .cur_mag_in(cur),
        .zero_cross_in(zc & ~zc_off), .freq_in(freq), .neg_seq_v_in(v2), .zero_seq_i_in(i0),
        .neg_seq_i_in(i2), .diff_ref_block_out(dblk), .resid_unbal_block_out(rblk),
        .broken_wire_out(bw), .vt_failure_block_out(vt), .irq_out(irq_out));
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // Waits n edges; settle adds 1 ns so registered outputs have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic settle(input int n);
        cyc(n);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        v = rd_data_out;
    endtask
    // Holds phase 0 at rated for arm cycles, then drops it with chosen frequency and neighbour currents
    task automatic bw_try(input logic [15:0] f, oth, input int arm, input logic e);
        cyc(1);
        cur <= {9{16'h0400}};
        freq <= 16'h1388;
        cyc(arm);
        freq <= f;
        cur <= {{6{16'h0400}}, oth, oth, 16'h0000};
        settle(3);
        chk(bw[0] === e && dblk[0] === e && rblk[0] === e, "wire verdict");
        chk(irq_out === e, "wire irq");
        rd(`CTW_ADDR_IRQSTAT, d);
        chk(d[0] === e, "wire status");
        cyc(1);
        cur <= {9{16'h0400}};
        freq <= 16'h1388;
        settle(3);
        chk(bw === 9'h0 && dblk === 3'h0 && irq_out === 1'b0, "wire release");
    endtask
    // Crossings stop on phase 0 while its current stays at rated
    task automatic bw_nozc();
        cyc(1);
        zc_off <= 9'h001;
        settle(300);
        chk(irq_out === 1'b1, "no crossing irq");
        rd(`CTW_ADDR_IRQSTAT, d);
        chk(d[0] === 1'b1, "no crossing event");
        cyc(1);
        zc_off <= 9'h000;
    endtask
    // Reset in mid-run while the monitor blocks; the mask must return to zero
    task automatic mid_reset();
        cyc(1);
        v2 <= 16'h0200;
        settle(3);
        chk(vt === 1'b1, "blocked before reset");
        cyc(1);
        srst_in <= 1'b1;
        v2 <= 16'h0000;
        settle(2);
        chk(vt === 1'b0 && irq_out === 1'b0, "reset clears block");
        cyc(1);
        srst_in <= 1'b0;
        rd(`CTW_ADDR_IRQMASK, d);
        chk(d === 32'h0 && vt === 1'b0, "mask back to reset");
    endtask
    task automatic ffm();
        wr(`CTW_ADDR_CTRL, 32'h13);
        v2 <= 16'h0200;
        i0 <= {16'h0100, 32'h0}; // Unselected location looks asymmetric
        settle(3);
        chk(vt === 1'b0, "single phase object");
        wr(`CTW_ADDR_CTRL, 32'h17);
        settle(3);
        chk(vt === 1'b1, "asymmetry blocks");
        cyc(1);
        i2 <= {32'h0, 16'h0100};
        settle(3);
        chk(vt === 1'b0, "fault releases");
        cyc(1);
        i2 <= 48'h0;
        settle(3);
        chk(vt === 1'b1, "blocks again");
        cyc(1);
        i0 <= {3{16'h0100}};
        settle(3);
        chk(vt === 1'b0, "earth fault releases");
        cyc(1);
        i0 <= 48'h0;
        settle(60);
        cyc(1);
        i0 <= {3{16'h0100}};
        settle(3);
        chk(vt === 1'b1, "latched block");
        rd(`CTW_ADDR_FFMSTAT, d);
        chk(d[3:0] === 4'hB, "latched state");
        rd(`CTW_ADDR_IRQSTAT, d);
        chk(d[2:1] === 2'b11, "fuse events");
        cyc(1);
        i0 <= 48'h0;
        v2 <= 16'h0000;
        settle(10);
        chk(vt === 1'b1, "hold keeps block");
        settle(40);
        chk(vt === 1'b0, "hold expires");
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        cyc(6);
        srst_in <= 1'b0;
        rd(`CTW_ADDR_CTRL, d);
        chk(d === 32'h17 && dblk === 3'h0 && vt === 1'b0, "reset state");
        rd(8'h3C, d);
        chk(d === 32'h0, "unmapped read");
        wr(`CTW_ADDR_IRQMASK, 32'h7);
        bw_try(16'h1388, 16'h0400, 100, 1'b1);
        bw_try(16'h1388, 16'h0400, 8, 1'b0);
        bw_try(16'h1676, 16'h0400, 100, 1'b0);
        bw_try(16'h1388, 16'h0900, 100, 1'b0);
        bw_nozc();
        ffm();
        mid_reset();
        print_verdict();
    end
endmodule
